// File: logic/fsf_pkg.sv
// shared constants and carrier types for the fast-settle / post filter decimator
package fsf_pkg;

  // ------------------------------------------------------------
  // system clock and modulator clock generation
  // ------------------------------------------------------------
  localparam longint REF_HZ = 100_000_000;   // ref_clk rate
  localparam longint MCLK_FULL_HZ = 614_400; // full power modulator clock
  localparam longint MCLK_MID_HZ = 153_600;  // mid power modulator clock
  localparam longint MCLK_LOW_HZ = 76_800;   // low power modulator clock
  localparam int PHASE_W = 32;               // phase accumulator width
  // phase increments: f_mclk / f_ref scaled to 2^32
  localparam logic [PHASE_W-1:0] INC_FULL = PHASE_W'((MCLK_FULL_HZ << PHASE_W) / REF_HZ);
  localparam logic [PHASE_W-1:0] INC_MID = PHASE_W'((MCLK_MID_HZ << PHASE_W) / REF_HZ);
  localparam logic [PHASE_W-1:0] INC_LOW = PHASE_W'((MCLK_LOW_HZ << PHASE_W) / REF_HZ);

  // ------------------------------------------------------------
  // power modes and filter selections
  // ------------------------------------------------------------
  localparam logic [1:0] PWR_LOW = 2'h0;
  localparam logic [1:0] PWR_MID = 2'h1;
  localparam logic [1:0] PWR_FULL = 2'h2;
  localparam logic [2:0] FILT_POST = 3'h7;   // all ones selects post filter
  localparam logic [1:0] POST_27 = 2'h0;     // 27.27 SPS
  localparam logic [1:0] POST_25 = 2'h1;     // 25 SPS
  localparam logic [1:0] POST_20 = 2'h2;     // 20 SPS
  localparam logic [1:0] POST_16 = 2'h3;     // 16.67 SPS

  // ------------------------------------------------------------
  // decimation, averaging and timing counts (modulator clocks)
  // ------------------------------------------------------------
  localparam int RATE_W = 11;                // rate_select_field width
  localparam logic [RATE_W-1:0] RATE_MIN = 11'h001;
  localparam logic [5:0] DECIM_BASE = 6'h20; // 32 modulator clocks per rate step
  localparam logic [1:0] SINC_FILL = 2'h2;   // order 3 minus one discarded outputs
  localparam logic [6:0] DEAD_FIRST = 7'h5f; // 95 clocks after a start or config change
  localparam logic [6:0] DEAD_SEQ = 7'h1e;   // 30 clocks inside a sequence
  localparam logic [5:0] AVG_FULL_MID = 6'h10; // average by 16
  localparam logic [5:0] AVG_LOW = 6'h08;    // average by 8
  // post filter: sinc3 runs at 600 SPS, averaging sets the final rate
  localparam logic [RATE_W-1:0] POST_RATE_FULL = 11'h020;
  localparam logic [RATE_W-1:0] POST_RATE_MID = 11'h008;
  localparam logic [RATE_W-1:0] POST_RATE_LOW = 11'h004;
  localparam logic [5:0] POST_N_27 = 6'h16;  // 22 results
  localparam logic [5:0] POST_N_25 = 6'h18;  // 24 results
  localparam logic [5:0] POST_N_20 = 6'h1e;  // 30 results
  localparam logic [5:0] POST_N_16 = 6'h24;  // 36 results
  // reciprocals of the average counts in q16
  localparam int RECIP_W = 14;
  localparam logic [RECIP_W-1:0] RECIP_16 = 14'h1000;
  localparam logic [RECIP_W-1:0] RECIP_8 = 14'h2000;
  localparam logic [RECIP_W-1:0] RECIP_22 = 14'h0ba3;
  localparam logic [RECIP_W-1:0] RECIP_24 = 14'h0aab;
  localparam logic [RECIP_W-1:0] RECIP_30 = 14'h0889;
  localparam logic [RECIP_W-1:0] RECIP_36 = 14'h071c;
  localparam int RECIP_SHIFT = 16;

  // ------------------------------------------------------------
  // datapath sizes and carriers
  // ------------------------------------------------------------
  localparam int CHAN_N = 8;
  localparam int CHAN_W = 3;
  localparam int DATA_W = 50;                // 3 x 16 bit growth plus 2 bit signed +1 / -1 input

  typedef struct packed {
    logic [1:0] power_mode;                  // PWR_* code
    logic [2:0] filter_type;                 // FILT_POST or fast settle
    logic [1:0] post_select;                 // POST_* code
    logic [RATE_W-1:0] rate_select_field;    // legal 1..2047
    logic [CHAN_N-1:0] chan_en;              // enabled channels
  } cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;                 // signed averaged sinc3 value
    logic [CHAN_W-1:0] chan;                 // channel it belongs to
  } result_t;

endpackage : fsf_pkg

// File: logic/fsf_averager.sv
// block averager: sums a programmable number of sinc3 results
`timescale 1ns/1ps
`default_nettype none
module fsf_averager #(
  parameter int DATA_W = 50,
  parameter int SUM_W = 56
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic [5:0] count,
  output logic out_valid,
  output logic [SUM_W-1:0] out_sum
);

  // ------------------------------------------------------------
  // accumulation
  // ------------------------------------------------------------
  logic [SUM_W-1:0] acc_q; // running sum of the current block
  logic [5:0] n_q;         // results taken into the block
  logic [SUM_W-1:0] acc_d; // sum including this input

  assign acc_d = acc_q + SUM_W'($signed(in_data));

  // non-overlapping blocks, so each output sees fresh data only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
      n_q <= '0;
      out_valid <= 1'b0;
      out_sum <= '0;
    end else begin
      out_valid <= 1'b0;
      if (clear) begin
        acc_q <= '0;
        n_q <= '0;
      end else if (in_valid) begin
        // last result of the block: hand over and restart
        if (n_q == count - 6'h01) begin
          out_sum <= acc_d;
          out_valid <= 1'b1;
          acc_q <= '0;
          n_q <= '0;
        end else begin
          acc_q <= acc_d;
          n_q <= n_q + 6'h01;
        end
      end
    end
  end

endmodule : fsf_averager
`default_nettype wire

// File: logic/fsf_decimator.sv
// sinc3 decimator with averaging / post filter stage and channel sequencing
`timescale 1ns/1ps
`default_nettype none
module fsf_decimator #(
  parameter int CHAN_N = fsf_pkg::CHAN_N
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic conv_en,
  input wire fsf_pkg::cfg_t cfg,
  input wire logic mod_bit_pin,
  output logic mod_clk_q,
  output fsf_pkg::result_t result_q,
  output logic data_new_q,
  output logic settling_q
);

  localparam int DW = fsf_pkg::DATA_W;
  localparam int SUM_W = DW + 6;
  localparam int PROD_W = SUM_W + fsf_pkg::RECIP_W;

  // ------------------------------------------------------------
  // modulator clock generation
  // ------------------------------------------------------------
  logic [fsf_pkg::PHASE_W-1:0] phase_q;  // fractional phase
  logic [fsf_pkg::PHASE_W-1:0] inc;      // per power mode increment
  logic [fsf_pkg::PHASE_W:0] phase_sum;  // carry marks one modulator clock
  logic tick_q;                          // one ref_clk per modulator clock

  // frequency follows the selected power mode
  always_comb begin
    case (cfg.power_mode)
      fsf_pkg::PWR_FULL: inc = fsf_pkg::INC_FULL;
      fsf_pkg::PWR_MID: inc = fsf_pkg::INC_MID;
      default: inc = fsf_pkg::INC_LOW;
    endcase
  end

  assign phase_sum = {1'b0, phase_q} + {1'b0, inc};

  // jitter of one ref_clk period; a clean source matters for the notches
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '0;
      tick_q <= 1'b0;
      mod_clk_q <= 1'b0;
    end else begin
      phase_q <= phase_sum[fsf_pkg::PHASE_W-1:0];
      tick_q <= phase_sum[fsf_pkg::PHASE_W];
      mod_clk_q <= phase_q[fsf_pkg::PHASE_W-1];
    end
  end

  // ------------------------------------------------------------
  // modulator bit synchroniser
  // ------------------------------------------------------------
  logic bit_meta_q; // first stage, read only by bit_sync_q
  logic bit_sync_q; // safe to use

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bit_meta_q <= 1'b0;
      bit_sync_q <= 1'b0;
    end else begin
      bit_meta_q <= mod_bit_pin;
      bit_sync_q <= bit_meta_q;
    end
  end

  // ------------------------------------------------------------
  // configuration decode
  // ------------------------------------------------------------
  logic post_mode;                      // post filter selected
  logic [fsf_pkg::RATE_W-1:0] rate_eff; // decimation rate in use
  logic [5:0] avg_n;                    // results per output
  logic [fsf_pkg::RECIP_W-1:0] recip;   // 1/avg_n in q16
  logic [15:0] dec_len;                 // 32 * rate modulator clocks

  assign post_mode = (cfg.filter_type == fsf_pkg::FILT_POST);

  // post filter pins the sinc3 rate at 600 SPS and picks the block length
  always_comb begin
    rate_eff = cfg.rate_select_field;
    avg_n = fsf_pkg::AVG_FULL_MID;
    recip = fsf_pkg::RECIP_16;
    if (cfg.power_mode == fsf_pkg::PWR_LOW) begin
      avg_n = fsf_pkg::AVG_LOW;
      recip = fsf_pkg::RECIP_8;
    end
    // zero is illegal; treat it as the smallest legal rate
    if (rate_eff == '0) begin
      rate_eff = fsf_pkg::RATE_MIN;
    end
    if (post_mode) begin
      case (cfg.power_mode)
        fsf_pkg::PWR_FULL: rate_eff = fsf_pkg::POST_RATE_FULL;
        fsf_pkg::PWR_MID: rate_eff = fsf_pkg::POST_RATE_MID;
        default: rate_eff = fsf_pkg::POST_RATE_LOW;
      endcase
      case (cfg.post_select)
        fsf_pkg::POST_27: begin
          avg_n = fsf_pkg::POST_N_27;
          recip = fsf_pkg::RECIP_22;
        end
        fsf_pkg::POST_25: begin
          avg_n = fsf_pkg::POST_N_25;
          recip = fsf_pkg::RECIP_24;
        end
        fsf_pkg::POST_20: begin
          avg_n = fsf_pkg::POST_N_20;
          recip = fsf_pkg::RECIP_30;
        end
        default: begin
          avg_n = fsf_pkg::POST_N_16;
          recip = fsf_pkg::RECIP_36;
        end
      endcase
    end
  end

  // first sinc notch sits at fclk / dec_len
  assign dec_len = 16'(rate_eff) * 16'(fsf_pkg::DECIM_BASE);

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_DEAD, S_RUN} state_t;

  localparam int CHAN_W_L = fsf_pkg::CHAN_W;

  state_t state_q;                // conversion phase
  fsf_pkg::cfg_t cfg_q;           // config seen last cycle
  logic conv_en_q;                // conv_en last cycle
  logic [6:0] dead_q;             // dead clocks still to wait
  logic [CHAN_W_L-1:0] chan_q;    // channel being converted
  logic restart;                  // manual start or config change
  logic advance;                  // sequenced move to next channel
  logic multi;                    // more than one channel enabled
  logic avg_valid;                // averager finished a block
  logic [SUM_W-1:0] avg_sum;      // averager block sum
  logic dec_hit;                  // decimation boundary this cycle

  // next enabled channel after cur, wrapping round
  function automatic logic [CHAN_W_L-1:0] next_chan(input logic [CHAN_N-1:0] en,
                                                    input logic [CHAN_W_L-1:0] cur);
    logic [CHAN_W_L-1:0] idx;
    logic found;
    next_chan = cur;
    found = 1'b0;
    for (int i = 1; i <= CHAN_N; i++) begin
      idx = CHAN_W_L'(int'(cur) + i);
      if (!found && en[idx]) begin
        next_chan = idx;
        found = 1'b1;
      end
    end
  endfunction : next_chan

  assign multi = (cfg.chan_en & (cfg.chan_en - 1'b1)) != '0;
  assign restart = (conv_en && !conv_en_q) || (conv_en && (cfg != cfg_q));
  assign advance = (state_q == S_RUN) && avg_valid && multi;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= '0;
      conv_en_q <= 1'b0;
    end else begin
      cfg_q <= cfg;
      conv_en_q <= conv_en;
    end
  end

  // state, dead time and channel choice
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      dead_q <= '0;
      chan_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (restart) begin
            state_q <= S_DEAD;
          end
        end
        S_DEAD: begin
          if (tick_q) begin
            if (dead_q == 7'h01) begin
              state_q <= S_RUN;
            end
            dead_q <= dead_q - 7'h01;
          end
        end
        S_RUN: begin
          // single channel stays here through input steps
          if (advance) begin
            state_q <= S_DEAD;
          end
        end
        default: state_q <= S_IDLE;
      endcase
      if (!conv_en) begin
        state_q <= S_IDLE;
      end else if (restart) begin
        state_q <= S_DEAD;
        dead_q <= fsf_pkg::DEAD_FIRST;
        chan_q <= next_chan(cfg.chan_en, CHAN_W_L'(CHAN_N - 1));
      end else if (advance) begin
        dead_q <= fsf_pkg::DEAD_SEQ;
        chan_q <= next_chan(cfg.chan_en, chan_q);
      end
    end
  end

  // ------------------------------------------------------------
  // sinc3 integrators and decimation counter
  // ------------------------------------------------------------
  logic [DW-1:0] int1_q, int2_q, int3_q; // integrator chain
  logic [15:0] dec_cnt_q;                // clocks into current period
  logic [DW-1:0] in_val;                 // +1 / -1 from the bit

  assign in_val = bit_sync_q ? DW'(1) : {DW{1'b1}};
  assign dec_hit = (state_q == S_RUN) && tick_q && (dec_cnt_q == dec_len - 16'h0001);

  // state is cleared outside a run so every conversion starts cold
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
      dec_cnt_q <= '0;
    end else if (state_q != S_RUN) begin
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
      dec_cnt_q <= '0;
    end else if (tick_q) begin
      int1_q <= int1_q + in_val;
      int2_q <= int2_q + int1_q + in_val; // forward sums keep no stale term
      int3_q <= int3_q + int2_q + int1_q + in_val;
      dec_cnt_q <= dec_hit ? 16'h0000 : dec_cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // sinc3 differentiators at the decimated rate
  // ------------------------------------------------------------
  logic [DW-1:0] z1_q, z2_q, z3_q; // delayed differences
  logic [DW-1:0] d1, d2, d3;       // comb outputs
  logic [DW-1:0] sinc_q;           // decimated sinc3 result
  logic sinc_vld_q;                // sinc_q fresh this cycle
  logic [1:0] fill_q;              // outputs still discarded

  assign d1 = int3_q - z1_q;
  assign d2 = d1 - z2_q;
  assign d3 = d2 - z3_q;

  // the first two outputs hold partial history and are thrown away
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      z1_q <= '0;
      z2_q <= '0;
      z3_q <= '0;
      sinc_q <= '0;
      sinc_vld_q <= 1'b0;
      fill_q <= fsf_pkg::SINC_FILL;
    end else begin
      sinc_vld_q <= 1'b0;
      if (state_q != S_RUN) begin
        z1_q <= '0;
        z2_q <= '0;
        z3_q <= '0;
        fill_q <= fsf_pkg::SINC_FILL;
      end else if (dec_hit) begin
        z1_q <= int3_q;
        z2_q <= d1;
        z3_q <= d2;
        sinc_q <= d3;
        if (fill_q != 2'h0) begin
          fill_q <= fill_q - 2'h1;
        end else begin
          sinc_vld_q <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // averaging or post filter block
  // ------------------------------------------------------------
  fsf_averager #(
    .DATA_W(DW),
    .SUM_W(SUM_W)
  ) u_avg (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(state_q != S_RUN),
    .in_valid(sinc_vld_q),
    .in_data(sinc_q),
    .count(avg_n),
    .out_valid(avg_valid),
    .out_sum(avg_sum)
  );

  // ------------------------------------------------------------
  // result register and new data flag
  // ------------------------------------------------------------
  logic [PROD_W-1:0] scaled; // sum times reciprocal

  assign scaled = PROD_W'($signed(avg_sum)) * PROD_W'(recip);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= '0;
      data_new_q <= 1'b0;
    end else begin
      data_new_q <= 1'b0;
      if (avg_valid && state_q == S_RUN) begin
        result_q.data <= scaled[fsf_pkg::RECIP_SHIFT +: DW];
        result_q.chan <= chan_q;
        data_new_q <= 1'b1;
      end
    end
  end

  // busy while no settled data is on the way
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      settling_q <= 1'b0;
    end else begin
      settling_q <= (state_q == S_DEAD) || (state_q == S_RUN && fill_q != 2'h0);
    end
  end

endmodule : fsf_decimator
`default_nettype wire

// File: verif/fsf_decimator_checker.sv
// concurrent checks on the ports of the fast-settle decimator
`timescale 1ns/1ps
`default_nettype none
module fsf_decimator_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic conv_en,
  input wire fsf_pkg::cfg_t cfg,
  input wire logic mod_bit_pin,
  input wire logic mod_clk_q,
  input wire fsf_pkg::result_t result_q,
  input wire logic data_new_q,
  input wire logic settling_q
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic [1:0] mode_q; // power mode seen one cycle ago
  logic [10:0] hi_q; // cycles the modulator clock has been high
  logic [10:0] hi_max; // longest legal high half for the mode

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // remember the mode so a change can restart the count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) mode_q <= 2'h0;
    else mode_q <= cfg.power_mode;
  end

  // count resets on a mode change, else a slow half is judged by a fast bound
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) hi_q <= 11'h000;
    else if (mod_clk_q && cfg.power_mode == mode_q) hi_q <= hi_q + 11'h001;
    else hi_q <= 11'h000;
  end

  // half periods plus one cycle of margin; code 3 runs at the low rate
  assign hi_max = (cfg.power_mode == fsf_pkg::PWR_FULL) ? 11'h053 :
                  (cfg.power_mode == fsf_pkg::PWR_MID) ? 11'h147 : 11'h28d;

  // ------------------------------------------------------------
  // sequences and assertions
  // ------------------------------------------------------------
  sequence settle_soon_s;
    ##[1:8] settling_q;
  endsequence
  sequence quiet_s;
    (!settling_q) [*8];
  endsequence
  sequence idle_s;
    (!conv_en) [*4];
  endsequence

  new_pulse_a: assert property (data_new_q |=> !data_new_q)
    else $error("new data flag held longer than one cycle");
  idle_quiet_a: assert property (idle_s |-> !data_new_q)
    else $error("result while conversion is off");
  dead_no_data_a: assert property (settling_q && $past(settling_q) |-> !data_new_q)
    else $error("result during settling");
  start_settle_a: assert property ($rose(conv_en) |-> settle_soon_s)
    else $error("start did not enter settling");
  result_hold_a: assert property ($changed(result_q) |-> data_new_q)
    else $error("result changed without new data flag");
  chan_enabled_a: assert property (data_new_q |-> cfg.chan_en[result_q.chan])
    else $error("result tagged with a disabled channel");
  seq_resettle_a: assert property (data_new_q && !$onehot(cfg.chan_en) |-> settle_soon_s)
    else $error("sequenced channel did not settle");
  single_run_a: assert property (data_new_q && $onehot(cfg.chan_en) |=> quiet_s)
    else $error("single channel settled again");
  clk_half_a: assert property (hi_q <= hi_max)
    else $error("modulator clock high too long");
endmodule : fsf_decimator_checker
`default_nettype wire

// File: verif/mod_model.sv
// modulator stand-in: a constant or stepped bitstream on the modulator clock
`timescale 1ns/1ps
`default_nettype none
module mod_model (
  input wire logic ref_clk,
  input wire logic mod_clk_q,
  input wire logic level,
  output logic mod_bit_pin
);
  logic clk_seen_q; // modulator clock seen at the last sample

  initial mod_bit_pin = 1'b1;
  initial clk_seen_q = 1'b0;

  // a new bit follows each falling modulator clock, stable at the next rise
  // relies on the generated clock being steady; jitter would smear the notches
  always @(negedge ref_clk) begin
    if (clk_seen_q && !mod_clk_q) mod_bit_pin <= level;
    clk_seen_q <= mod_clk_q;
  end
endmodule : mod_model
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the fast-settle decimator
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {
    logic [2:0] chan; // channel the result must carry
    int ticks; // modulator clocks since the previous mark
    logic [49:0] data; // expected average
    logic use_data; // off for a result spanning a step
  } note_t;

  // ------------------------------------------------------------
  // signals and state
  // ------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic conv_en = 1'b0;
  fsf_pkg::cfg_t cfg = '0;
  logic level = 1'b1; // bitstream level the model sends
  logic mod_bit_pin;
  logic mod_clk_q;
  logic data_new_q;
  logic settling_q;
  fsf_pkg::result_t result_q;
  note_t notes[$]; // expected results, oldest first
  note_t t;
  int fails = 0;
  int n_tests = 0;
  int seed = 82421;
  int tick = 0; // modulator clock rises so far
  int mark = 0; // tick of the last start or result
  int avg;
  int a;
  int b;
  int n;
  longint per_exp;
  logic [49:0] dv;

  always #5 ref_clk = ~ref_clk;
  always @(posedge mod_clk_q) tick <= tick + 1;

  fsf_decimator fsf_decimator_i (.ref_clk(ref_clk), .nrst(nrst), .conv_en(conv_en), .cfg(cfg),
    .mod_bit_pin(mod_bit_pin), .mod_clk_q(mod_clk_q), .result_q(result_q),
    .data_new_q(data_new_q), .settling_q(settling_q));
  mod_model mod_model_i (.ref_clk(ref_clk), .mod_clk_q(mod_clk_q), .level(level),
    .mod_bit_pin(mod_bit_pin));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task stop_test;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // adds the cycles up to the next modulator clock rise, bounded
  task wait_rise(inout int cyc);
    int j;
    j = 0;
    while (j < 6000 && mod_clk_q !== 1'b0) begin
      @(negedge ref_clk);
      j++;
    end
    while (j < 6000 && mod_clk_q !== 1'b1) begin
      @(negedge ref_clk);
      j++;
    end
    cyc += j;
    if (j >= 6000) begin
      check(1'b0, "modulator clock stalled");
      stop_test();
    end
  endtask : wait_rise

  // waits until at most k notes are left, bounded
  task wait_left(input int k);
    int j;
    for (j = 0; j < 250000 && notes.size() > k; j++) @(negedge ref_clk);
    if (notes.size() > k) begin
      check(1'b0, "result missing");
      stop_test();
    end
  endtask : wait_left

  task note(input int ch, input int tk, input logic ud);
    notes.push_back('{3'(ch), tk, dv, ud});
  endtask : note

  // ------------------------------------------------------------
  // result watcher: one note is taken off per new result
  // ------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (data_new_q === 1'b1) begin
      if (notes.size() == 0) check(1'b0, "result with no note");
      else begin
        t = notes.pop_front();
        check(result_q.chan === t.chan, "channel");
        check(tick - mark >= t.ticks - 2 && tick - mark <= t.ticks + 2, "timing");
        if (t.use_data) check(result_q.data === t.data, "average");
        mark = tick;
      end
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(negedge ref_clk);
    check(mod_clk_q === 1'b0 && data_new_q === 1'b0 && settling_q === 1'b0, "reset");
    nrst = 1'b1;
    // four clock periods per mode; code 3 falls back to the low rate
    for (int m = 0; m < 4; m++) begin
      cfg.power_mode = 2'(m);
      n = 0;
      wait_rise(n);
      n = 0;
      repeat (4) wait_rise(n);
      per_exp = 4 * fsf_pkg::REF_HZ / (m == 2 ? fsf_pkg::MCLK_FULL_HZ :
                m == 1 ? fsf_pkg::MCLK_MID_HZ : fsf_pkg::MCLK_LOW_HZ);
      check(n >= per_exp - 2 && n <= per_exp + 2, "modulator clock rate");
    end
    // one random channel, full power, rate 1; input steps inside the second block
    a = $unsigned($random(seed)) % 8;
    cfg = '{fsf_pkg::PWR_FULL, 3'h0, fsf_pkg::POST_27, fsf_pkg::RATE_MIN, 8'(1 << a)};
    avg = 16;
    dv = 50'(32768);
    note(a, (3 + avg - 1) * 32 + 95, 1'b1);
    note(a, avg * 32, 1'b0);
    conv_en = 1'b1;
    mark = tick;
    wait_left(1);
    repeat ($unsigned($random(seed)) % 4000) @(negedge ref_clk);
    level = 1'b0;
    wait_left(0);
    repeat (10) @(negedge ref_clk);
    conv_en = 1'b0;
    repeat (10) @(negedge ref_clk);
    // two random channels: lowest first, the next one with the short dead time
    b = (a + 1 + $unsigned($random(seed)) % 7) % 8;
    cfg.chan_en = 8'((1 << a) | (1 << b));
    dv = 50'(-32768);
    note(a < b ? a : b, (3 + avg - 1) * 32 + 95, 1'b1);
    note(a < b ? b : a, (3 + avg - 1) * 32 + 30, 1'b1);
    conv_en = 1'b1;
    mark = tick;
    wait_left(0);
    repeat (10) @(negedge ref_clk);
    conv_en = 1'b0;
    repeat (10) @(negedge ref_clk);
    stop_test();
  end
endmodule : tb

bind fsf_decimator fsf_decimator_checker fsf_decimator_checker_i (.ref_clk(ref_clk),
  .nrst(nrst), .conv_en(conv_en), .cfg(cfg), .mod_bit_pin(mod_bit_pin),
  .mod_clk_q(mod_clk_q), .result_q(result_q), .data_new_q(data_new_q),
  .settling_q(settling_q));
`default_nettype wire
